// ### wwd_pkg.sv
// Constants and field layout of the windowed watchdog
package wwd_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MODE_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    // Control register fields
    localparam int KEY_LSB = 24;
    localparam int KEY_W = 8;
    localparam logic [7:0] KEY_VALUE = 8'ha5;
    localparam int RESTART_BIT = 0;
    // Mode register fields
    localparam int CNT_W = 12;
    localparam int LOAD_LSB = 0;
    localparam int FIEN_BIT = 12;
    localparam int RSTEN_BIT = 13;
    localparam int RPROC_BIT = 14;
    localparam int DIS_BIT = 15;
    localparam int WIN_LSB = 16;
    localparam int DBGHLT_BIT = 28;
    localparam int IDLEHLT_BIT = 29;
    localparam logic [31:0] MODE_MASK = 32'h3fff_ffff;
    localparam logic [31:0] MODE_RST = 32'h3fff_2fff;
    // Status register fields
    localparam int UNF_BIT = 0;
    localparam int ERR_BIT = 1;
    // Slow clock prescaler and counter constants
    localparam int PRE_DIV = 128;
    localparam int PRE_W = 7;
    localparam logic [PRE_W-1:0] PRE_LAST = 7'h7f;
    localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
endpackage

// ### wwd_top.sv
// Windowed watchdog timer with key-protected restart and write-once mode
`timescale 1ns/1ns

// What this block does
// RQ1 - Twelve-bit down counter loaded from mode
// RQ2 - Counter steps on slow clock divided 128
// RQ3 - Reset: load 0xFFF, fault reset enabled
// RQ4 - Mode register accepts only first write
// RQ5 - Accepted mode write reloads and restarts counter
// RQ6 - Valid restart reloads counter and restarts
// RQ7 - Valid restart also clears the prescaler
// RQ8 - Control write with wrong key ignored
// RQ9 - Software writes key 0xA5 each time
// RQ10 - Underflow drives fault only if reset enabled
// RQ11 - Underflow always sets underflow flag
// RQ12 - Both flags sticky until status read
// RQ13 - Restart accepted only within window limit
// RQ14 - Early restart flags error, drives fault always
// RQ15 - Window at or above load: always accepted
// RQ16 - Either flag raises interrupt when enabled
// RQ17 - Watchdog reset clears block and flags
// RQ18 - Processor-only bit selects reset scope
// RQ19 - Reset or status read clears flags, fault
// RQ20 - Counter halts in debug or idle when enabled
// RQ21 - Unused watchdog disabled by software mode write
// RQ22 - Fault requests general or processor reset only
// RQ23 - Underflow on tick at zero, flagged once
module wwd_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slck_i,
    input wire logic debug_i,
    input wire logic idle_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output logic fault_o,
    output logic gen_rst_o,
    output logic proc_rst_o,
    output logic [11:0] count_o
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // Load field of a mode word, from the register or from the bus
    function automatic logic [wwd_pkg::CNT_W-1:0] load_field(input logic [31:0] w);
        load_field = w[wwd_pkg::LOAD_LSB +: wwd_pkg::CNT_W];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic slck_m_r;
    logic slck_s_r;
    logic slck_d_r;
    logic dbg_m_r;
    logic dbg_s_r;
    logic idle_m_r;
    logic idle_s_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slck_m_r <= 1'b0;
            slck_s_r <= 1'b0;
            slck_d_r <= 1'b0;
            dbg_m_r <= 1'b0;
            dbg_s_r <= 1'b0;
            idle_m_r <= 1'b0;
            idle_s_r <= 1'b0;
        end else begin
            slck_m_r <= slck_i;
            slck_s_r <= slck_m_r;
            slck_d_r <= slck_s_r;
            dbg_m_r <= debug_i;
            dbg_s_r <= dbg_m_r;
            idle_m_r <= idle_i;
            idle_s_r <= idle_m_r;
        end
    end

    logic slck_rise;
    assign slck_rise = slck_s_r & ~slck_d_r;

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [31:0] mode_r;
    logic [31:0] mode_nxt;
    logic mode_done_r;
    logic mode_done_nxt;
    logic [wwd_pkg::CNT_W-1:0] cnt_r;
    logic [wwd_pkg::CNT_W-1:0] cnt_nxt;
    logic [wwd_pkg::PRE_W-1:0] pre_r;
    logic [wwd_pkg::PRE_W-1:0] pre_nxt;
    logic unf_r;
    logic unf_nxt;
    logic err_r;
    logic err_nxt;
    logic fault_r;
    logic fault_nxt;
    logic irq_r;
    logic irq_nxt;
    logic gen_rst_r;
    logic gen_rst_nxt;
    logic proc_rst_r;
    logic proc_rst_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Decoded mode fields

    logic [wwd_pkg::CNT_W-1:0] load_value;
    logic [wwd_pkg::CNT_W-1:0] restart_window_limit;
    logic fault_irq_enable;
    logic fault_reset_enable;
    logic processor_only_reset;
    logic watchdog_disable;
    logic debug_halt;
    logic idle_halt;

    assign load_value = load_field(mode_r);  // [RQ1]
    assign restart_window_limit = mode_r[wwd_pkg::WIN_LSB +: wwd_pkg::CNT_W];
    assign fault_irq_enable = mode_r[wwd_pkg::FIEN_BIT];
    assign fault_reset_enable = mode_r[wwd_pkg::RSTEN_BIT];
    assign processor_only_reset = mode_r[wwd_pkg::RPROC_BIT];
    assign watchdog_disable = mode_r[wwd_pkg::DIS_BIT];
    assign debug_halt = mode_r[wwd_pkg::DBGHLT_BIT];
    assign idle_halt = mode_r[wwd_pkg::IDLEHLT_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic ctrl_wr;
    logic mode_wr;
    logic stat_rd;
    logic key_ok;
    logic restart_command;
    logic in_window;
    logic restart_ok;
    logic restart_bad;

    assign ctrl_wr = wr_i & addr_hit(addr_i, wwd_pkg::CTRL_OFS);
    assign mode_wr = wr_i & addr_hit(addr_i, wwd_pkg::MODE_OFS) & ~mode_done_r;  // [RQ4]
    assign stat_rd = rd_i & addr_hit(addr_i, wwd_pkg::STAT_OFS);
    assign key_ok = (wdata_i[wwd_pkg::KEY_LSB +: wwd_pkg::KEY_W] == wwd_pkg::KEY_VALUE);  // [RQ8] [RQ9]
    assign restart_command = ctrl_wr & key_ok & wdata_i[wwd_pkg::RESTART_BIT];  // [RQ8]
    // Window check; a limit at or above the load value admits any count
    assign in_window = (cnt_r <= restart_window_limit)
                     | (restart_window_limit >= load_value);  // [RQ13] [RQ15]
    assign restart_ok = restart_command & in_window;  // [RQ13]
    assign restart_bad = restart_command & ~in_window;  // [RQ14]

    ////////////////////////////////////////////////////////////////////////
    // Counting

    logic running;
    logic tick;
    logic underflow;

    // Disabled, or halted by debug or idle state
    assign running = ~watchdog_disable
                   & ~(debug_halt & dbg_s_r)
                   & ~(idle_halt & idle_s_r);  // [RQ20] [RQ21]
    assign tick = running & slck_rise & (pre_r == wwd_pkg::PRE_LAST);  // [RQ2]
    assign underflow = tick & (cnt_r == wwd_pkg::CNT_ZERO);  // [RQ23]

    always_comb begin
        mode_nxt = mode_r;
        mode_done_nxt = mode_done_r;
        cnt_nxt = cnt_r;
        pre_nxt = pre_r;
        if (mode_wr) begin
            mode_nxt = wdata_i & wwd_pkg::MODE_MASK;  // [RQ4]
            mode_done_nxt = 1'b1;  // [RQ4]
            cnt_nxt = load_field(wdata_i);  // [RQ5]
            pre_nxt = wwd_pkg::PRE_ZERO;  // [RQ5]
        end else if (restart_ok) begin
            cnt_nxt = load_value;  // [RQ6]
            pre_nxt = wwd_pkg::PRE_ZERO;  // [RQ7]
        end else begin
            if (running && slck_rise) begin
                pre_nxt = pre_r + 7'h01;  // [RQ2]
            end
            if (underflow) begin
                // Reload so each underflow is seen only once
                cnt_nxt = load_value;  // [RQ23] [RQ1]
            end else if (tick) begin
                cnt_nxt = cnt_r - wwd_pkg::CNT_ONE;  // [RQ1]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= wwd_pkg::MODE_RST;  // [RQ3] [RQ4]
            mode_done_r <= 1'b0;  // [RQ4]
            cnt_r <= wwd_pkg::MODE_RST[wwd_pkg::CNT_W-1:0];  // [RQ3]
            pre_r <= wwd_pkg::PRE_ZERO;
        end else begin
            mode_r <= mode_nxt;
            mode_done_r <= mode_done_nxt;
            cnt_r <= cnt_nxt;
            pre_r <= pre_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags, fault and interrupt

    logic unf_set;
    logic fault_set;
    logic fault_cur;

    assign unf_set = underflow;  // [RQ11]
    // Error faults regardless of enable; underflow only when reset enabled
    assign fault_set = restart_bad | (underflow & fault_reset_enable);  // [RQ10] [RQ14]

    always_comb begin
        unf_nxt = unf_r;
        err_nxt = err_r;
        fault_nxt = fault_r;
        if (stat_rd) begin
            unf_nxt = 1'b0;  // [RQ19]
            err_nxt = 1'b0;  // [RQ19]
            fault_nxt = 1'b0;  // [RQ19]
        end
        // Set wins over a clearing read in the same cycle
        if (unf_set) begin
            unf_nxt = 1'b1;  // [RQ11] [RQ12]
        end
        if (restart_bad) begin
            err_nxt = 1'b1;  // [RQ14] [RQ12]
        end
        if (fault_set) begin
            fault_nxt = 1'b1;  // [RQ10] [RQ14]
        end
        fault_cur = fault_nxt;
        irq_nxt = (unf_nxt | err_nxt) & fault_irq_enable;  // [RQ16]
        gen_rst_nxt = fault_cur & fault_reset_enable & ~processor_only_reset;  // [RQ18] [RQ22]
        proc_rst_nxt = fault_cur & fault_reset_enable & processor_only_reset;  // [RQ18] [RQ22]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // A watchdog reset comes back here through the reset input
            unf_r <= 1'b0;  // [RQ17] [RQ19]
            err_r <= 1'b0;  // [RQ17] [RQ19]
            fault_r <= 1'b0;  // [RQ19]
            irq_r <= 1'b0;  // [RQ19]
            gen_rst_r <= 1'b0;
            proc_rst_r <= 1'b0;
        end else begin
            unf_r <= unf_nxt;
            err_r <= err_nxt;
            fault_r <= fault_nxt;
            irq_r <= irq_nxt;
            gen_rst_r <= gen_rst_nxt;
            proc_rst_r <= proc_rst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd_i) begin
            if (addr_hit(addr_i, wwd_pkg::MODE_OFS)) begin
                rdata_nxt = mode_r;
            end else if (addr_hit(addr_i, wwd_pkg::STAT_OFS)) begin
                rdata_nxt[wwd_pkg::UNF_BIT] = unf_r;
                rdata_nxt[wwd_pkg::ERR_BIT] = err_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata_o = rdata_r;
    assign irq_o = irq_r;
    assign fault_o = fault_r;
    assign gen_rst_o = gen_rst_r;
    assign proc_rst_o = proc_rst_r;
    assign count_o = cnt_r;

endmodule

// ### wwd_checker.sv
// Property checker for the windowed watchdog
`timescale 1ns/1ns
module wwd_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic debug_i,
    input wire logic idle_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic irq_o,
    input wire logic fault_o,
    input wire logic gen_rst_o,
    input wire logic proc_rst_o,
    input wire logic [11:0] count_o
);
    logic [31:0] mode_r, mode_nxt;
    logic done_r, done_nxt, mwr, cwr, bad, early;
    assign mwr = wr_i && addr_i == wwd_pkg::MODE_OFS;
    assign bad = wr_i && addr_i == wwd_pkg::CTRL_OFS && wdata_i[31:24] != wwd_pkg::KEY_VALUE;
    assign cwr = wr_i && addr_i == wwd_pkg::CTRL_OFS && !bad && wdata_i[0];
    assign early = cwr && count_o > mode_r[27:16] && mode_r[27:16] < mode_r[11:0];
    // Shadow of the write-once mode register
    always_comb begin
        mode_nxt = mode_r;
        done_nxt = done_r | mwr;
        if (mwr && !done_r) begin
            mode_nxt = wdata_i & wwd_pkg::MODE_MASK;
        end
    end
    always_ff @(posedge clk_i) begin
        mode_r <= rst_i ? wwd_pkg::MODE_RST : mode_nxt;
        done_r <= rst_i ? 1'b0 : done_nxt;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_halted;
        (((debug_i && mode_r[28]) || (idle_i && mode_r[29])) && !wr_i)[*6];
    endsequence
    property p_inert(logic trig);
        trig && count_o != 12'h000 |=> count_o == $past(count_o) || count_o == $past(count_o) - 12'h001;
    endproperty
    ////////////////////////////////////////
    a_restart_reloads: assert property (cwr && !early |=> count_o == mode_r[11:0])
        else $error("restart in window did not reload");
    a_early_faults: assert property (early |=> fault_o && irq_o == mode_r[12])
        else $error("early restart not flagged");
    a_bad_key: assert property (p_inert(bad))
        else $error("wrong key changed the counter");
    a_mode_once: assert property (p_inert(mwr && done_r))
        else $error("second mode write took effect");
    a_mode_reload: assert property (mwr && !done_r |=> count_o == $past(wdata_i[11:0]))
        else $error("mode write did not reload");
    a_unf_flags: assert property ($past(count_o) == 12'h000 && count_o != 12'h000 && !$past(wr_i) |->
        (fault_o || !mode_r[13]) && (irq_o || !mode_r[12])) else $error("underflow not signalled");
    a_count_steps: assert property (count_o != $past(count_o) |-> count_o == $past(count_o) - 12'h001 ||
        $past(count_o) == 12'h000 || $past(wr_i)) else $error("counter jumped");
    a_read_clears: assert property (rd_i && addr_i == wwd_pkg::STAT_OFS && count_o != 12'h000 |=>
        !fault_o && !irq_o) else $error("status read left fault");
    a_gen_scope: assert property (gen_rst_o |-> (fault_o || $past(fault_o)) && mode_r[13] && !mode_r[14])
        else $error("general reset out of scope");
    a_proc_scope: assert property (proc_rst_o |-> (fault_o || $past(fault_o)) && mode_r[13] && mode_r[14])
        else $error("processor reset out of scope");
    a_halt_freezes: assert property (s_halted |=> $stable(count_o))
        else $error("counter ran while halted");
endmodule
bind wwd_top wwd_checker chk (.clk_i(clk_i), .rst_i(rst_i), .debug_i(debug_i), .idle_i(idle_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .irq_o(irq_o), .fault_o(fault_o),
    .gen_rst_o(gen_rst_o), .proc_rst_o(proc_rst_o), .count_o(count_o));

// ### wwd_rstc_model.sv
// Reset controller model answering watchdog reset requests
`timescale 1ns/1ns
module wwd_rstc_model (
    input wire logic clk_i,
    input wire logic gen_rst_i,
    input wire logic proc_rst_i,
    output logic rst_o
);
    logic [2:0] cnt_r = 3'h0;
    logic [2:0] cnt_nxt;
    always_comb begin
        cnt_nxt = (cnt_r == 3'h0) ? 3'h0 : cnt_r - 3'h1;
        if ((gen_rst_i || proc_rst_i) && cnt_r == 3'h0) begin
            cnt_nxt = 3'h4;
        end
    end
    always_ff @(posedge clk_i) begin
        cnt_r <= cnt_nxt;
    end
    assign rst_o = cnt_r != 3'h0;
endmodule

// ### tb_wwd_top.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ns
module tb_wwd_top;
    logic clk_i = 1'b0, tb_rst = 1'b1, slck_i = 1'b0, debug_i = 1'b0, idle_i = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0, irq_o, fault_o, gen_rst_o, proc_rst_o, rc_rst, rst_i;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, rd_v, seed = 32'hb;
    logic [11:0] count_o, snap;
    int num_errors = 0, n_tests = 0, cyc = 0, n, k;
    always #5 clk_i = ~clk_i;
    always begin
        repeat (2) @(posedge clk_i);
        slck_i <= ~slck_i;
    end
    assign rst_i = tb_rst || rc_rst;
    wwd_top dut (.clk_i(clk_i), .rst_i(rst_i), .slck_i(slck_i), .debug_i(debug_i), .idle_i(idle_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .fault_o(fault_o), .gen_rst_o(gen_rst_o), .proc_rst_o(proc_rst_o), .count_o(count_o));
    wwd_rstc_model rstc (.clk_i(clk_i), .gen_rst_i(gen_rst_o), .proc_rst_i(proc_rst_o), .rst_o(rc_rst));
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Flags are disable, processor-only, reset enable, irq enable
    function automatic logic [31:0] mw(input logic [11:0] ld, input logic [11:0] win, input logic [3:0] f);
        return {4'h3, win, f, ld};
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        rd_v = rdata_o;
    endtask
    task automatic wait_for(input int sel);
        for (n = 0; n < 5000; n++) begin
            @(posedge clk_i);
            #1;
            if ((sel == 0 && irq_o === 1'b1) || (sel == 1 && fault_o === 1'b1) || (sel == 2 && count_o <= 12'h1))
                break;
        end
        chk("wait", 32'h0, {31'h0, n == 5000});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            final_report;
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        tb_rst <= 1'b0;
        rd(wwd_pkg::MODE_OFS);
        chk("mode reset", 32'h3fff_2fff, rd_v);
        chk("count reset", 32'hfff, {20'h0, count_o});
        wr(wwd_pkg::MODE_OFS, mw(12'h003, 12'h001, 4'h1));
        chk("mode load", 32'h3, {20'h0, count_o});
        for (k = 0; k < 4; k++) begin
            seed = xs(seed);
            wr(wwd_pkg::CTRL_OFS, {(seed[31:24] == 8'ha5) ? 8'h00 : seed[31:24], seed[23:1], 1'b1});
            chk("bad key", 32'h6, {19'h0, count_o, fault_o});
        end
        wr(wwd_pkg::MODE_OFS, mw(12'h007, 12'h007, 4'h0));
        rd(wwd_pkg::MODE_OFS);
        chk("mode once", mw(12'h003, 12'h001, 4'h1), rd_v);
        wr(wwd_pkg::CTRL_OFS, 32'ha500_0001);
        chk("early", 32'h6, {29'h0, irq_o, fault_o, gen_rst_o | proc_rst_o});
        rd(wwd_pkg::STAT_OFS);
        chk("err flag", 32'h2, rd_v);
        chk("cleared", 32'h0, {30'h0, irq_o, fault_o});
        wait_for(0);
        chk("unf fault", 32'h0, {31'h0, fault_o});
        rd(wwd_pkg::STAT_OFS);
        chk("unf flag", 32'h1, rd_v);
        wait_for(2);
        repeat (300) @(posedge clk_i);
        wr(wwd_pkg::CTRL_OFS, 32'ha500_0001);
        chk("restart", 32'h3, {20'h0, count_o});
        repeat (470) @(posedge clk_i);
        #1;
        chk("prescaler", 32'h3, {20'h0, count_o});
        for (k = 0; k < 2; k++) begin
            @(posedge clk_i);
            debug_i <= (k == 0);
            idle_i <= (k == 1);
            repeat (6) @(posedge clk_i);
            snap = count_o;
            repeat (1100) @(posedge clk_i);
            chk("halt", {20'h0, snap}, {20'h0, count_o});
        end
        @(posedge clk_i);
        debug_i <= 1'b0;
        idle_i <= 1'b0;
        for (k = 0; k < 2; k++) begin
            @(posedge clk_i);
            tb_rst <= 1'b1;
            repeat (2) @(posedge clk_i);
            tb_rst <= 1'b0;
            seed = xs(seed);
            wr(wwd_pkg::MODE_OFS, mw({10'h0, seed[1:0]}, 12'hfff, {1'b0, k[0], 2'b10}));
            wr(wwd_pkg::CTRL_OFS, 32'ha500_0001);
            chk("any window", {19'h0, 10'h0, seed[1:0], 1'b0}, {19'h0, count_o, fault_o});
            wait_for(1);
            @(posedge clk_i);
            #1;
            chk("scope", {30'h0, k[0], ~k[0]}, {30'h0, proc_rst_o, gen_rst_o});
            repeat (8) @(posedge clk_i);
            rd(wwd_pkg::STAT_OFS);
            chk("wd reset", 32'hfff, {rd_v[19:0], count_o});
        end
        wr(wwd_pkg::MODE_OFS, mw(12'h005, 12'h000, 4'h8));
        repeat (1100) @(posedge clk_i);
        #1;
        chk("disabled", 32'h5, {20'h0, count_o});
        wr(wwd_pkg::CTRL_OFS, 32'ha500_0001);
        chk("err disabled", 32'h1, {31'h0, fault_o});
        rd(8'h0c);
        chk("unmapped", 32'h0, rd_v);
        final_report;
    end
endmodule
